// ==== core/serial_front_end.sv ====
`timescale 1ns/10ps
module serial_front_end #(
	parameter int bit_clocks = smem_pkg::BIT_TIME_CLOCKS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Pins
	input wire logic link_clk,
	input wire logic rst_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Configuration
	input wire logic [3:0] dev_addr,
	input wire logic [63:0] atr_value,
	// Bytes for sync reads
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Received write data
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic [3:0] rx_zone,
	output logic write_commit,
	// Status
	output logic async_mode,
	output logic standby
);
	typedef enum logic [2:0] {
		s_idle, s_get, s_ack, s_put, s_hack, s_areset, s_atr, s_aidle
	} state_e;

	state_e state, next_state;
	logic [2:0] sy1, sy2, prv, pins;
	logic scl_rise, scl_fall, sda, rst, start, stop;
	logic [3:0] cnt, next_cnt, bit_idx, next_bit, sent, next_sent;
	logic [3:0] push, next_push, next_rx_zone;
	logic [7:0] sh, next_sh, page, next_page, next_rx_data, byte_in, load;
	logic [8:0] tick, next_tick;
	logic is_addr, next_is_addr, is_read, next_is_read, hack, next_hack;
	logic zone_done, next_zone_done, busy, next_busy, next_oe;
	logic next_rx_valid, next_commit, next_async, next_standby, pop;

	byte_stream_if #(.width(smem_pkg::BYTE_W)) fin ();
	byte_stream_if #(.width(smem_pkg::BYTE_W)) fout ();

	byte_fifo #(
		.width(smem_pkg::BYTE_W),
		.depth(smem_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.wr(fin),
		.rd(fout)
	);

	assign pins = {rst_pin, sda_in, link_clk};

	// Pull-up: reset pin synchroniser starts inactive high
	genvar g;
	for (g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				sy1[g] <= smem_pkg::SYNC_RESET[g];
				sy2[g] <= smem_pkg::SYNC_RESET[g];
				prv[g] <= smem_pkg::SYNC_RESET[g];
			end else begin
				sy1[g] <= pins[g];
				sy2[g] <= sy1[g];
				prv[g] <= sy2[g];
			end
		end
	end

	assign sda = sy2[smem_pkg::PIN_SDA];
	assign rst = sy2[smem_pkg::PIN_RST];
	assign scl_rise = sy2[smem_pkg::PIN_CLK] && !prv[smem_pkg::PIN_CLK];
	assign scl_fall = !sy2[smem_pkg::PIN_CLK] && prv[smem_pkg::PIN_CLK];
	// Data moving while the clock stays high is framing, not data
	assign start = sy2[smem_pkg::PIN_CLK] && prv[smem_pkg::PIN_CLK]
		&& !sda && prv[smem_pkg::PIN_SDA];
	assign stop = sy2[smem_pkg::PIN_CLK] && prv[smem_pkg::PIN_CLK]
		&& sda && !prv[smem_pkg::PIN_SDA];

	// Async character: start, eight data bits LSB first, even parity, guard
	function automatic logic frame_bit(input logic [3:0] idx,
		input logic [7:0] b);
		logic v;
		v = 1'b1;
		if (idx == 4'h0) begin
			v = 1'b0;
		end else if (idx <= 4'h8) begin
			v = b[3'(idx - 4'h1)];
		end else if (idx == 4'(smem_pkg::FRAME_PARITY)) begin
			v = ^b;
		end
		return v;
	endfunction : frame_bit

	// Answer-to-reset bytes share the FIFO with sync read data
	assign fin.valid = (state == s_atr) ?
		(push < 4'(smem_pkg::ATR_BYTES)) : tx_valid;
	assign fin.data = (state == s_atr) ?
		atr_value[{push[2:0], 3'h0} +: 8] : tx_data;
	assign fout.ready = pop;
	assign tx_ready = fin.ready;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_sh = sh;
		next_is_addr = is_addr;
		next_is_read = is_read;
		next_hack = hack;
		next_page = page;
		next_zone_done = zone_done;
		next_oe = sda_oe;
		next_rx_data = rx_data;
		next_rx_valid = 1'b0;
		next_rx_zone = rx_zone;
		next_commit = 1'b0;
		next_async = async_mode;
		next_tick = tick;
		next_bit = bit_idx;
		next_sent = sent;
		next_busy = busy;
		next_push = push;
		pop = 1'b0;
		byte_in = {sh[6:0], sda};
		load = fout.valid ? fout.data : smem_pkg::IDLE_BYTE;
		if (state == s_atr && fin.valid && fin.ready) begin
			next_push = push + 4'h1;
		end
		unique case (state)
			s_idle, s_aidle: begin
			end
			s_get: begin
				if (scl_rise) begin
					next_sh = byte_in;
					next_cnt = cnt + 4'h1;
					if (cnt == 4'(smem_pkg::BYTE_LAST_BIT)) begin
						next_cnt = 4'h0;
						next_state = s_ack;
						if (is_addr) begin
							if (byte_in[7:4] != dev_addr) begin
								next_state = s_idle;
							end
							next_is_read = byte_in[smem_pkg::READ_BIT];
						end else if (!zone_done) begin
							next_rx_zone = byte_in[3:0];
							next_zone_done = 1'b1;
						end else if (page < 8'(smem_pkg::PAGE_BYTES)) begin
							next_rx_data = byte_in;
							next_rx_valid = 1'b1;
							next_page = page + 8'h1;
						end else begin
							next_state = s_idle;
						end
					end
				end
			end
			s_ack: begin
				if (scl_fall) begin
					if (!sda_oe) begin
						next_oe = 1'b1;
					end else begin
						next_is_addr = 1'b0;
						next_cnt = 4'h0;
						next_oe = 1'b0;
						if (is_read) begin
							pop = fout.valid;
							next_sh = load;
							next_oe = !load[7];
							next_state = s_put;
						end else begin
							next_state = s_get;
						end
					end
				end
			end
			s_put: begin
				if (scl_rise) begin
					next_cnt = cnt + 4'h1;
				end else if (scl_fall) begin
					if (cnt == 4'(smem_pkg::ACK_FALLS)) begin
						next_oe = 1'b0;
						next_state = s_hack;
					end else begin
						next_sh = {sh[6:0], 1'b1};
						next_oe = !sh[6];
					end
				end
			end
			s_hack: begin
				if (scl_rise) begin
					next_hack = !sda;
				end else if (scl_fall) begin
					if (hack) begin
						pop = fout.valid;
						next_sh = load;
						next_oe = !load[7];
						next_cnt = 4'h0;
						next_state = s_put;
					end else begin
						next_state = s_idle;
					end
				end
			end
			s_areset: begin
				if (rst) begin
					next_state = s_atr;
					next_push = 4'h0;
					next_sent = 4'h0;
					next_busy = 1'b0;
				end
			end
			s_atr: begin
				if (!busy) begin
					if (fout.valid) begin
						pop = 1'b1;
						next_sh = fout.data;
						next_busy = 1'b1;
						next_bit = 4'h0;
						next_tick = 9'h0;
						next_oe = 1'b1;
					end
				end else if (scl_rise) begin
					if (tick == 9'(bit_clocks - 1)) begin
						next_tick = 9'h0;
						next_bit = bit_idx + 4'h1;
						next_oe = !frame_bit(bit_idx + 4'h1, sh);
						if (bit_idx == 4'(smem_pkg::FRAME_LAST)) begin
							next_busy = 1'b0;
							next_oe = 1'b0;
							next_sent = sent + 4'h1;
							if (sent == 4'(smem_pkg::ATR_BYTES - 1)) begin
								next_state = s_aidle;
							end
						end
					end else begin
						next_tick = tick + 9'h1;
					end
				end
			end
		endcase
		// Framing on the two-wire bus only counts once sync mode holds
		if (!async_mode && start) begin
			next_state = s_get;
			next_is_addr = 1'b1;
			next_cnt = 4'h0;
			next_oe = 1'b0;
			next_page = 8'h0;
			next_zone_done = 1'b0;
		end else if (!async_mode && stop) begin
			next_state = s_idle;
			next_oe = 1'b0;
			next_commit = !is_read && page != 8'h0 && state != s_idle;
		end
		// A low reset pin always wins and selects the async protocol
		if (!rst) begin
			next_async = 1'b1;
			next_state = s_areset;
			next_oe = 1'b0;
		end
		next_standby = next_state == s_idle;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= s_idle;
			cnt <= 4'h0;
			sh <= 8'h0;
			is_addr <= 1'b0;
			is_read <= 1'b0;
			hack <= 1'b0;
			page <= 8'h0;
			zone_done <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			rx_data <= 8'h0;
			rx_valid <= 1'b0;
			rx_zone <= 4'h0;
			write_commit <= 1'b0;
			async_mode <= 1'b0;
			standby <= 1'b1;
			tick <= 9'h0;
			bit_idx <= 4'h0;
			sent <= 4'h0;
			busy <= 1'b0;
			push <= 4'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sh <= next_sh;
			is_addr <= next_is_addr;
			is_read <= next_is_read;
			hack <= next_hack;
			page <= next_page;
			zone_done <= next_zone_done;
			sda_oe <= next_oe;
			sda_out <= 1'b0;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
			rx_zone <= next_rx_zone;
			write_commit <= next_commit;
			async_mode <= next_async;
			standby <= next_standby;
			tick <= next_tick;
			bit_idx <= next_bit;
			sent <= next_sent;
			busy <= next_busy;
			push <= next_push;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	a_bit_length: assert property (busy && $past(busy) && $changed(bit_idx)
		|-> $past(tick) == 9'(bit_clocks - 1))
		else $error("async bit ended before its full bit time");
	a_sample_rise: assert property ((state == s_get) && !scl_rise
		&& !start |=> $stable(sh))
		else $error("sync shifter moved without a rising clock");
	a_drive_fall: assert property (!async_mode && !$past(async_mode)
		&& $changed(sda_oe) |-> $past(scl_fall) || $past(start || stop))
		else $error("sync data changed away from a falling clock");
	a_atr_count: assert property (state == s_aidle
		|-> sent == 4'(smem_pkg::ATR_BYTES))
		else $error("answer-to-reset ended with wrong byte count");
	a_no_sync_atr: assert property (!async_mode |-> state != s_atr
		&& state != s_areset)
		else $error("answer-to-reset started in sync mode");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_idle_release: assert property (state == s_idle
		|=> !sda_oe || $past(start))
		else $error("data pin held low in idle");
	a_addr_match: assert property (state == s_get && is_addr && scl_rise
		&& cnt == 4'h7 && byte_in[7:4] != dev_addr && rst && !start && !stop
		|=> state == s_idle ##1 !sda_oe)
		else $error("answered a foreign address");
	a_page_limit: assert property (page <= 8'(smem_pkg::PAGE_BYTES))
		else $error("page count ran past its limit");
	a_page_pulse: assert property (rx_valid
		|-> $past(page) < 8'(smem_pkg::PAGE_BYTES))
		else $error("page write ran past its limit");
	a_start_frame: assert property (!async_mode && start && rst
		|=> state == s_get && is_addr && cnt == 4'h0)
		else $error("start did not open an address byte");
	a_stop_idle: assert property (!async_mode && stop && rst
		|=> standby && !sda_oe)
		else $error("stop did not return to standby");
endmodule : serial_front_end

// ==== common/smem_pkg.sv ====
// Notes on behaviour
// - Async mode: every bit on the data pin lasts 372 carrier clock cycles.
// - Sync mode: incoming data is sampled on the rising serial clock edge.
// - Sync mode: outgoing data changes on the falling serial clock edge.
// - On reset sequence, send the 64-bit answer-to-reset value over the async link.
// - Reset pin idles inactive (pull-up), so an unconnected pin means sync mode.
// - No answer-to-reset is ever produced in sync mode.
// - The data pin is only pulled low or released, in both protocols.
// - Up to 16 devices share the sync bus; answer only our own address.
// - Async link may be sped up by parameter selection, up to 153,600 baud.
// - Writes take one byte or a page of up to 128 bytes, then commit.
// - User memory is 16 zones of 256 bytes, each selected separately.
// - Sync data changes only while clock is low; changes when high are framing.
// - Data falling while clock high is a start; it precedes every command.
// - Data rising while clock high is a stop; it puts the device in standby.
package smem_pkg;
	localparam int BIT_TIME_CLOCKS = 372;
	localparam int BAUD_MAX = 153600;
	localparam int SYNC_KHZ_MAX = 1000;
	localparam int ATR_BYTES = 8;
	localparam int ATR_BITS = 64;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int ADDR_W = 4;
	localparam int ADDR_LSB = 4;
	localparam int READ_BIT = 0;
	localparam int ZONES = 16;
	localparam int ZONE_BYTES = 256;
	localparam int PAGE_BYTES = 128;
	localparam int BYTE_LAST_BIT = 7;
	localparam int ACK_FALLS = 8;
	localparam int FRAME_PARITY = 9;
	localparam int FRAME_LAST = 11;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam logic [2:0] SYNC_RESET = 3'h7;
	localparam int PIN_CLK = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_RST = 2;
endpackage : smem_pkg

// ==== common/byte_stream_if.sv ====
`timescale 1ns/10ps
interface byte_stream_if #(parameter int width = 8);
	logic [width-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// ==== core/byte_fifo.sv ====
`timescale 1ns/10ps
module byte_fifo #(
	parameter int width = 8,
	parameter int depth = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Streams
	byte_stream_if.snk wr,
	byte_stream_if.src rd
);
	localparam int AW = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic [AW:0] count, next_count;
	logic room, next_room, push, pull;

	always_comb begin
		push = wr.valid && room;
		pull = rd.valid && rd.ready;
		next_wp = wp;
		next_rp = rp;
		if (push) begin
			next_wp = (wp == AW'(depth - 1)) ? '0 : wp + 1'b1;
		end
		if (pull) begin
			next_rp = (rp == AW'(depth - 1)) ? '0 : rp + 1'b1;
		end
		next_count = count + (AW + 1)'(push) - (AW + 1)'(pull);
		// Ready is a flop so the top can hand it straight out
		next_room = next_count < (AW + 1)'(depth);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			room <= 1'b1;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			count <= next_count;
			room <= next_room;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp] <= wr.data;
		end
	end

	assign wr.ready = room;
	assign rd.valid = count != '0;
	assign rd.data = mem[rp];
endmodule : byte_fifo

// ==== verif/host_model.sv ====
`timescale 1ns/10ps
module host_model (
	// Wires
	output logic scl,
	output logic sda_low,
	output logic rst_pin,
	input wire logic sda
);
	logic carrier_on;
	int glitches;
	// Reset pin idles high, as the internal pull-up holds it
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		rst_pin = 1'b1;
		carrier_on = 1'b0;
		glitches = 0;
	end
	// Carrier runs free once the async link is in use
	always #62.5 if (carrier_on) scl = ~scl;
	// Bus clock is kept short for run time; the block gets about fifteen
	// system clocks per half period of it
	// Data moves only in the middle of the low phase
	task automatic put_bit(input logic b);
		#31 sda_low = ~b;
		#31 scl = 1'b1;
		#62 scl = 1'b0;
	endtask : put_bit
	// Line is sampled twice while high; a change there is counted
	task automatic get_bit(output logic b);
		#31 sda_low = 1'b0;
		#31 scl = 1'b1;
		#31 b = sda;
		#31 if (sda !== b) glitches++;
		scl = 1'b0;
	endtask : get_bit
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(b);
		ack = ~b;
	endtask : send_byte
	task automatic recv_byte(input logic ack, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) get_bit(v[i]);
		put_bit(~ack);
	endtask : recv_byte
	task automatic start;
		#31 sda_low = 1'b0;
		#31 scl = 1'b1;
		#62 sda_low = 1'b1;
		#62 scl = 1'b0;
	endtask : start
	task automatic stop;
		#31 sda_low = 1'b1;
		#31 scl = 1'b1;
		#62 sda_low = 1'b0;
		#62;
	endtask : stop
	task automatic atr_reset;
		carrier_on = 1'b1;
		rst_pin = 1'b0;
		#2000 rst_pin = 1'b1;
	endtask : atr_reset
endmodule : host_model

// ==== verif/serial_front_end_tb.sv ====
`timescale 1ns/10ps
module serial_front_end_tb;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic [63:0] atr = 64'h0123_4567_89ab_cdef;
	logic link_clk, rst_pin, sda_low, sda, sda_out, sda_oe, tx_ready;
	logic rx_valid, write_commit, async_mode, standby;
	logic [7:0] rx_data, rx_last;
	logic [3:0] rx_zone;
	int n_fail = 0;
	int n_checks = 0;
	int rx_count = 0;
	int commits = 0;
	int out_bad = 0;
	// Open-drain wire with pull-up: low if either side pulls
	assign sda = ~(sda_low | sda_oe);
	always #2 clock = ~clock;
	host_model host (.scl(link_clk), .sda_low(sda_low), .rst_pin(rst_pin),
		.sda(sda));
	serial_front_end #(.bit_clocks(4)) uut (.clock(clock), .resetn(resetn),
		.link_clk(link_clk), .rst_pin(rst_pin), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .dev_addr(4'h9),
		.atr_value(atr), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_zone(rx_zone), .write_commit(write_commit),
		.async_mode(async_mode), .standby(standby));
	always @(negedge clock) begin
		if (rx_valid === 1'b1) begin
			rx_count++;
			rx_last = rx_data;
		end
		if (write_commit === 1'b1) commits++;
		if (sda_out !== 1'b0) out_bad++;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic t_idle;
		logic seen_oe;
		seen_oe = 1'b0;
		repeat (200) @(negedge clock) seen_oe |= sda_oe;
		check(async_mode, 1'b0);
		check(seen_oe, 1'b0);
		check(standby, 1'b1);
	endtask : t_idle
	// Zone byte then n data bytes; only the first 128 are taken
	task automatic t_write(input int n, input logic [3:0] zone);
		logic ack;
		int base;
		base = rx_count;
		host.start();
		host.send_byte(8'h90, ack);
		check(ack, 1'b1);
		host.send_byte({4'h0, zone}, ack);
		check(ack, 1'b1);
		check(rx_zone, zone);
		for (int i = 0; i < n; i++) begin
			host.send_byte(i[7:0] ^ 8'h5a, ack);
			check(ack, i < 128);
		end
		check(rx_count - base, (n > 128) ? 128 : n);
		check(rx_last, ((n > 128) ? 127 : n - 1) ^ 8'h5a);
		base = commits;
		host.stop();
		repeat (10) @(negedge clock);
		check(commits - base, (n <= 128) ? 1 : 0);
		check(standby, 1'b1);
	endtask : t_write
	task automatic t_wrong;
		logic ack;
		int base;
		base = rx_count;
		host.start();
		host.send_byte(8'h30, ack);
		check(ack, 1'b0);
		host.send_byte(8'h01, ack);
		check(ack, 1'b0);
		host.stop();
		check(rx_count, base);
	endtask : t_wrong
	task automatic push(input logic [7:0] v);
		@(negedge clock);
		check(tx_ready, 1'b1);
		tx_data = v;
		tx_valid = 1'b1;
		@(negedge clock);
		tx_valid = 1'b0;
	endtask : push
	task automatic t_read;
		logic ack;
		logic [7:0] v;
		push(8'h3c);
		push(8'hc3);
		host.start();
		host.send_byte(8'h91, ack);
		check(ack, 1'b1);
		host.recv_byte(1'b1, v);
		check(v, 8'h3c);
		host.recv_byte(1'b1, v);
		check(v, 8'hc3);
		host.recv_byte(1'b0, v);
		check(v, 8'hff);
		host.stop();
		repeat (10) @(negedge clock);
		check(standby, 1'b1);
		check(host.glitches, 0);
	endtask : t_read
	// Samples each bit in its middle by counting carrier rises
	task automatic t_atr;
		logic [10:0] bits;
		int k;
		host.atr_reset();
		repeat (8) @(negedge clock);
		check(async_mode, 1'b1);
		for (int c = 0; c < 8; c++) begin
			k = 0;
			while (sda !== 1'b0 && k < 20000) begin
				@(posedge clock);
				k++;
			end
			check(k < 20000, 1'b1);
			if (k >= 20000) results();
			repeat (2) @(posedge link_clk);
			for (int b = 0; b < 11; b++) begin
				repeat (4) @(posedge link_clk);
				bits[b] = sda;
			end
			check(bits[7:0], atr[8*c +: 8]);
			check(bits[8], ^bits[7:0]);
			check(bits[10:9], 2'h3);
		end
	endtask : t_atr
	initial begin
		repeat (16) @(negedge clock);
		resetn = 1'b1;
		t_idle();
		t_write(1, 4'h3);
		t_write(129, 4'hc);
		t_wrong();
		t_read();
		t_atr();
		check(out_bad, 0);
		results();
	end
	initial begin
		repeat (95000) @(posedge clock);
		n_fail++;
		results();
	end
endmodule : serial_front_end_tb
